// [bench/hbd_fault_diagnostic_config_pin_props.sv]
// Checker for the fault and diagnostic block, SPI variant.
// Assumes one core clock and sync active-low reset.
`timescale 1ns/1ps
module hbd_fault_diagnostic_config_pin_props (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic in_sleep,
	input wire logic in_active,
	input wire logic [1:0] diagnostic_select_field,
	input wire logic tsd_retry_mode,
	input wire logic warning_report_enable,
	input wire logic clear_faults_command,
	input wire logic fault_flag_out_oe,
	input wire logic output_hiz,
	input wire logic current_sense_hiz,
	input wire logic current_sense_pull_limit,
	input wire logic off_diagnostic_config_pin_on,
	input wire logic on_diagnostic_config_pin_on,
	input wire logic regulation_on,
	input hbd_pkg::hbd_report_s report,
	input wire logic [15:0] status_frame
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	////////////////
	chk_sel_decode: assert property (off_diagnostic_config_pin_on == diagnostic_select_field[0]
		&& on_diagnostic_config_pin_on == diagnostic_select_field[1]
		&& regulation_on == !diagnostic_select_field[1])
		else $error("select decode wrong");
	chk_sleep_release: assert property (in_sleep [*3]
		|-> !fault_flag_out_oe && !report.fault) else $error("sleep kept fault");
	chk_fault_mirror: assert property (in_active && $past(in_active)
		|-> fault_flag_out_oe == report.fault) else $error("pin not mirror");
	chk_ocp_reaction: assert property ($rose(report.overcurrent_protection) && in_active
		|-> output_hiz ##2 fault_flag_out_oe) else $error("ocp reaction");
	chk_hs_limit: assert property ($rose(report.ocp_hs)
		&& !current_sense_hiz
		|-> current_sense_pull_limit) else $error("sense not at limit");
	chk_tsd_hiz: assert property ($rose(report.thermal_shutdown)
		|-> output_hiz && current_sense_hiz) else $error("tsd not hi-z");
	chk_tsd_latched: assert property (report.thermal_shutdown && !tsd_retry_mode
		&& !in_sleep && !clear_faults_command && !$past(clear_faults_command)
		|=> report.thermal_shutdown) else $error("latched tsd lost");
	chk_warn_report: assert property (report.temperature_warning_bit && warning_report_enable
		&& !in_sleep |=> report.fault) else $error("warning not reported");
	chk_frame_upper: assert property (status_frame[15:5] == 11'h0)
		else $error("frame upper bits set");
	cover property ($rose(report.overcurrent_protection));
	cover property ($rose(report.thermal_shutdown));
	cover property ($fell(report.temperature_warning_bit));
endmodule // hbd_fault_diagnostic_config_pin_props
bind hbd_fault_diagnostic_config_pin hbd_fault_diagnostic_config_pin_props u_props (.*);

// [bench/hbd_load_model.sv]
// Off-state load seen by the output node, as a comparator level.
// Assumes rail-level node voltages, so the reference choice never flips it.
`timescale 1ns/1ps
module hbd_load_model (
	input hbd_pkg::hbd_olp_setup_s olp_setup,
	input wire logic load_high_side,
	input wire logic [1:0] load_cond,
	output logic olp_comparator
);
	// Normal follows the load rail, open follows the pull, short the far rail
	always_comb begin
		case (load_cond)
			2'h0: olp_comparator = load_high_side;
			2'h1: olp_comparator = olp_setup.pull_up;
			default: olp_comparator = !load_high_side;
		endcase
	end
endmodule // hbd_load_model

// [bench/tb.sv]
// Self-checking bench for the fault and diagnostic block.
// Assumes the SPI variant with shortened retry, clear and thermal filter counts.
`timescale 1ns/1ps
module tb;
	localparam int NC = 20;
	localparam logic [11:0] OLP_TRUTH = 12'h2e6;
	logic core_clk, rst_n, init_pulse, in_sleep, in_standby, in_active;
	logic sleep_control_pin_n, drive_disable_pin, drive_input_pin;
	logic [1:0] diagnostic_config_pin, diagnostic_select_field, ocp_level_select;
	logic ocp_filter_select, ocp_retry_mode, tsd_retry_mode;
	logic [1:0] warning_threshold_select, load_cond;
	logic warning_report_enable, input_reg_unlocked, reg_pull_up, reg_pull_down;
	logic reg_ref_high, clear_faults_command, ocp_on_high_side, load_high_side;
	logic [3:0] ocp_over_level, temp_over_warning;
	logic temp_warning_below_hys, temp_over_tsd, temp_below_tsd_hys;
	logic olp_comparator, fault_flag_out_oe, fault_flag_out_n, output_hiz;
	logic current_sense_hiz, current_sense_pull_limit, off_diagnostic_config_pin_on, on_diagnostic_config_pin_on;
	logic regulation_on;
	logic [2:0] su;
	logic [15:0] status_frame;
	hbd_pkg::hbd_olp_setup_s olp_setup;
	hbd_pkg::hbd_report_s report;
	int miscompares, compares;
	hbd_fault_diagnostic_config_pin #(.RETRY_CYCLES(NC), .CLEAR_CYCLES(NC), .TSD_CLEAR_CYCLES(NC),
		.OTW_FILT_CYCLES(NC), .TSD_FILT_CYCLES(NC)) dut (.*);
	hbd_load_model u_load (.olp_setup, .load_high_side, .load_cond,
		.olp_comparator);
	////////////////
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic clear_all;
		clear_faults_command = 1'b1;
		step(1);
		clear_faults_command = 1'b0;
		step(4);
	endtask
	initial begin
		repeat (6000) @(posedge core_clk);
		miscompares++;
		final_report;
	end
	////////////////
	initial begin
		{rst_n, init_pulse, in_sleep, in_active, diagnostic_config_pin,
			diagnostic_select_field, ocp_level_select, ocp_filter_select,
			ocp_retry_mode, tsd_retry_mode, warning_threshold_select, load_cond,
			warning_report_enable, input_reg_unlocked, reg_pull_up, reg_pull_down,
			reg_ref_high, clear_faults_command, ocp_on_high_side, load_high_side,
			ocp_over_level, temp_over_warning, temp_warning_below_hys,
			temp_over_tsd, temp_below_tsd_hys} = '0;
		{sleep_control_pin_n, drive_disable_pin, drive_input_pin} = 3'h7;
		in_standby = 1'b1;
		step(16);
		rst_n = 1'b1;
		init_pulse = 1'b1;
		step(1);
		init_pulse = 1'b0;
		for (int s = 0; s < 4; s++) begin
			diagnostic_select_field = 2'(s);
			step(1);
			chk("diagnostic_config_pin_decode", {13'h0, off_diagnostic_config_pin_on, on_diagnostic_config_pin_on, regulation_on},
				{13'h0, s[0], s[1], ~s[1]});
		end
		$display("test select done");
		input_reg_unlocked = 1'b1;
		for (int i = 0; i < 12; i++) begin
			load_high_side = 1'(i / 6);
			load_cond = 2'(i % 3);
			su = ((i / 3) % 2) ? 3'b010 : 3'b101;
			{reg_pull_up, reg_pull_down, reg_ref_high} = su;
			diagnostic_select_field = ((i / 3) % 2) ? 2'h3 : 2'h1;
			step(5);
			chk("olp_setup", {13'h0, olp_setup}, {13'h0, su});
			chk("off_state_comparator_result", {15'h0, report.off_state_comparator_result}, {15'h0, OLP_TRUTH[i]});
		end
		input_reg_unlocked = 1'b0;
		step(5);
		chk("pin_cmp", {15'h0, fault_flag_out_oe}, {15'h0, !olp_comparator});
		chk("pin_setup", {13'h0, olp_setup}, 16'h0002);
		drive_input_pin = 1'b0;
		step(1);
		chk("olp_suppress", {13'h0, olp_setup}, 16'h0000);
		drive_input_pin = 1'b1;
		$display("test offstate done");
		{input_reg_unlocked, diagnostic_select_field} = 3'h4;
		{in_standby, in_active} = 2'h1;
		temp_over_tsd = 1'b1;
		step(NC + 6);
		chk("tsd_flag", {13'h0, report.thermal_shutdown, output_hiz, current_sense_hiz}, 16'h0007);
		{temp_over_tsd, temp_below_tsd_hys} = 2'h1;
		step(3 * NC);
		chk("tsd_held", {14'h0, report.thermal_shutdown, fault_flag_out_oe}, 16'h0003);
		chk("frame_active", status_frame, 16'h0018);
		clear_all;
		chk("tsd_clear", {14'h0, report.thermal_shutdown, fault_flag_out_oe}, 16'h0000);
		{tsd_retry_mode, temp_over_tsd, temp_below_tsd_hys} = 3'h6;
		step(NC + 6);
		chk("tsd_retry_set", {15'h0, report.thermal_shutdown}, 16'h0001);
		{temp_over_tsd, temp_below_tsd_hys} = 2'h1;
		step(NC + 8);
		chk("tsd_retry_off", {14'h0, report.thermal_shutdown, output_hiz}, 16'h0002);
		clear_all;
		$display("test thermal done");
		{ocp_level_select, ocp_on_high_side, ocp_retry_mode} = 4'hb;
		ocp_over_level = 4'hb;
		step(320);
		chk("ocp_other_level", {15'h0, report.overcurrent_protection}, 16'h0000);
		ocp_over_level = 4'h4;
		step(315);
		chk("ocp_trip", {12'h0, report.overcurrent_protection, report.ocp_hs, output_hiz,
			current_sense_pull_limit}, 16'h000f);
		chk("ocp_pin", {15'h0, fault_flag_out_oe}, 16'h0001);
		ocp_over_level = 4'h0;
		step(60);
		chk("ocp_retry", {14'h0, report.overcurrent_protection, output_hiz}, 16'h0002);
		clear_all;
		ocp_filter_select = 1'b1;
		ocp_over_level = 4'h4;
		step(500);
		chk("ocp_long_wait", {15'h0, report.overcurrent_protection}, 16'h0000);
		step(120);
		chk("ocp_long_trip", {15'h0, report.overcurrent_protection}, 16'h0001);
		ocp_over_level = 4'h0;
		step(60);
		clear_all;
		$display("test overcurrent done");
		{in_standby, in_active} = 2'h2;
		{warning_threshold_select, warning_report_enable} = 3'h3;
		temp_over_warning = 4'h2;
		step(NC + 8);
		chk("otw_set", {13'h0, report.temperature_warning_bit, report.fault, fault_flag_out_oe},
			16'h0007);
		chk("frame_standby", status_frame, 16'h0014);
		{temp_over_warning, temp_warning_below_hys} = 5'h01;
		step(8);
		chk("otw_auto_clear", {15'h0, report.temperature_warning_bit}, 16'h0000);
		clear_all;
		chk("otw_record_clear", {15'h0, report.fault}, 16'h0000);
		$display("test warning done");
		{in_standby, in_active, tsd_retry_mode, temp_over_tsd} = 4'h5;
		temp_below_tsd_hys = 1'b0;
		step(NC + 8);
		chk("sleep_pre", {15'h0, fault_flag_out_oe}, 16'h0001);
		chk("pin_level", {15'h0, fault_flag_out_n}, 16'h0000);
		{in_sleep, in_standby, in_active, temp_over_tsd} = 4'h8;
		step(4);
		chk("sleep_release", {14'h0, report.fault, fault_flag_out_oe}, 16'h0000);
		$display("test sleep done");
		final_report;
	end
endmodule // tb

// [hdl/hbd_fault_diagnostic_config_pin.sv]
// Protection and diagnostic control of a half-bridge driver.
// Assumes analog comparators arrive asynchronously and are synchronised
// here; host inputs come from same-clock command logic.
//
// Operation
// - Pin variant latches diagnostic pin at init; later pin changes ignored.
// - Two-bit select: none, off-state only, on-state only, both.
// - SPI select write takes effect immediately whenever communication runs.
// - Fault output pulled low on fault, released on entering sleep.
// - SPI fault output inverts summary bit, except locked off-state shows comparator.
// - Asserted fault output logs records; only clear command or sleep clears them.
// - One 16-bit frame: first report in active, second in standby.
// - Active overcurrent beyond filter flags fault, asserts output, output Hi-Z.
// - High-side overcurrent keeps current-sense pulled to limit after disable.
// - Overcurrent reaction latched or retry using retry and clear times.
// - Software selects overcurrent threshold and filter time.
// - Standby/active warning over threshold beyond filter sets warning bit.
// - Warning-report enable makes warning assert fault output and summary bit.
// - Warning bit clears automatically below hysteresis point.
// - Thermal event beyond filter flags shutdown, output and sense Hi-Z.
// - Thermal shutdown reaction latched or retry via hysteresis and clear time.
// - Off-state setup chosen by pins, or unlocked input-register bits.
// - Pin variant drives off-state comparator on fault output when enabled.
// - SPI comparator in second report; also on output when locked and enabled.
// - Low-side load: 01b pull-up high ref; 11b pull-down low ref.
// - High-side load: same setups, normal readings high.
`timescale 1ns/1ps
module hbd_fault_diagnostic_config_pin #(
	parameter bit SPI_VARIANT = 1'b1,
	parameter int RETRY_CYCLES = hbd_pkg::RETRY_CYC,
	parameter int CLEAR_CYCLES = hbd_pkg::CLEAR_CYC,
	parameter int TSD_CLEAR_CYCLES = hbd_pkg::TSD_CLEAR_CYC,
	parameter int OTW_FILT_CYCLES = hbd_pkg::OTW_FILT_CYC,
	parameter int TSD_FILT_CYCLES = hbd_pkg::TSD_FILT_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	// Device state
	input wire logic init_pulse,
	input wire logic in_sleep,
	input wire logic in_standby,
	input wire logic in_active,
	// Pins (already synchronised by caller domain)
	input wire logic sleep_control_pin_n,
	input wire logic drive_disable_pin,
	input wire logic drive_input_pin,
	input wire logic [1:0] diagnostic_config_pin,
	// Register-side configuration
	input wire logic [1:0] diagnostic_select_field,
	input wire logic [1:0] ocp_level_select,
	input wire logic ocp_filter_select,
	input wire logic ocp_retry_mode,
	input wire logic tsd_retry_mode,
	input wire logic [1:0] warning_threshold_select,
	input wire logic warning_report_enable,
	input wire logic input_reg_unlocked,
	input wire logic reg_pull_up,
	input wire logic reg_pull_down,
	input wire logic reg_ref_high,
	input wire logic clear_faults_command,
	// Asynchronous analog comparators
	input wire logic [3:0] ocp_over_level,
	input wire logic ocp_on_high_side,
	input wire logic [3:0] temp_over_warning,
	input wire logic temp_warning_below_hys,
	input wire logic temp_over_tsd,
	input wire logic temp_below_tsd_hys,
	input wire logic olp_comparator,
	// Outputs
	output logic fault_flag_out_oe,
	output logic fault_flag_out_n,
	output logic output_hiz,
	output logic current_sense_hiz,
	output logic current_sense_pull_limit,
	output logic off_diagnostic_config_pin_on,
	output logic on_diagnostic_config_pin_on,
	output logic regulation_on,
	output hbd_pkg::hbd_olp_setup_s olp_setup,
	output hbd_pkg::hbd_report_s report,
	output logic [15:0] status_frame
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for analog inputs
	localparam int SW = 12;
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	logic [SW-1:0] async_in;
	assign async_in = {ocp_over_level, ocp_on_high_side, temp_over_warning,
		temp_warning_below_hys, temp_over_tsd, temp_below_tsd_hys};
	logic olp_s1_q;
	logic olp_s2_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			olp_s1_q <= 1'b0;
			olp_s2_q <= 1'b0;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
			olp_s1_q <= olp_comparator;
			olp_s2_q <= olp_s1_q;
		end
	end

	logic [3:0] ocp_lvl_s;
	logic ocp_hs_s;
	logic [3:0] otw_lvl_s;
	logic otw_hys_s;
	logic tsd_s;
	logic tsd_hys_s;
	assign ocp_lvl_s = sync2_q[11:8];
	assign ocp_hs_s = sync2_q[7];
	assign otw_lvl_s = sync2_q[6:3];
	assign otw_hys_s = sync2_q[2];
	assign tsd_s = sync2_q[1];
	assign tsd_hys_s = sync2_q[0];

	////////////////////////////////////////////////////////////////////////
	// Diagnostic mode selection
	logic [1:0] pin_sel_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			pin_sel_q <= hbd_pkg::DSEL_RST;
		else if (init_pulse)
			pin_sel_q <= diagnostic_config_pin;
	end

	logic [1:0] dsel;
	// Register select used combinationally so writes act at once
	assign dsel = SPI_VARIANT ? diagnostic_select_field : pin_sel_q;
	assign off_diagnostic_config_pin_on = dsel[0];
	assign on_diagnostic_config_pin_on = dsel[1];
	assign regulation_on = !dsel[1];

	// Off-state setup: 01b pull-up/high ref, 11b pull-down/low ref
	logic use_reg;
	assign use_reg = SPI_VARIANT && input_reg_unlocked;
	always_comb begin
		olp_setup = '0;
		if (in_standby && off_diagnostic_config_pin_on) begin
			if (use_reg) begin
				olp_setup.pull_up = reg_pull_up;
				olp_setup.pull_down = reg_pull_down;
				olp_setup.ref_high = reg_ref_high;
			end else if (sleep_control_pin_n && drive_disable_pin
				&& drive_input_pin) begin
				olp_setup.pull_up = !dsel[1];
				olp_setup.pull_down = dsel[1];
				olp_setup.ref_high = !dsel[1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overcurrent filter and reaction
	logic [hbd_pkg::CNT_W-1:0] ocp_cnt_q;
	logic [hbd_pkg::CNT_W-1:0] ocp_lim;
	logic ocp_over;
	assign ocp_over = ocp_lvl_s[ocp_level_select];
	assign ocp_lim = ocp_filter_select ?
		hbd_pkg::CNT_W'(hbd_pkg::OCP_FILT1_CYC) :
		hbd_pkg::CNT_W'(hbd_pkg::OCP_FILT0_CYC);
	logic ocp_q;
	logic ocp_hs_q;
	logic [31:0] ocp_rt_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			ocp_cnt_q <= '0;
		else if (!(in_active && ocp_over) || ocp_q)
			ocp_cnt_q <= '0;
		else if (ocp_cnt_q != ocp_lim)
			ocp_cnt_q <= ocp_cnt_q + 1'b1;
	end

	logic ocp_det;
	assign ocp_det = in_active && ocp_over && ocp_cnt_q == ocp_lim;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ocp_q <= 1'b0;
			ocp_hs_q <= 1'b0;
			ocp_rt_q <= '0;
		end else if (in_sleep) begin
			ocp_q <= 1'b0;
			ocp_hs_q <= 1'b0;
			ocp_rt_q <= '0;
		end else if (ocp_det) begin
			ocp_q <= 1'b1;
			ocp_hs_q <= ocp_hs_s;
			ocp_rt_q <= '0;
		end else if (ocp_q && ocp_retry_mode) begin
			// Retry: wait retry time, then clear time
			if (ocp_rt_q == 32'(RETRY_CYCLES + CLEAR_CYCLES)) begin
				ocp_q <= 1'b0;
				ocp_hs_q <= 1'b0;
				ocp_rt_q <= '0;
			end else
				ocp_rt_q <= ocp_rt_q + 1'b1;
		end else if (ocp_q && clear_faults_command) begin
			ocp_q <= 1'b0;
			ocp_hs_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Temperature warning
	logic [31:0] otw_cnt_q;
	logic otw_q;
	logic otw_over;
	logic live;
	assign live = in_standby || in_active;
	assign otw_over = otw_lvl_s[warning_threshold_select];

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			otw_cnt_q <= '0;
		else if (!(live && otw_over))
			otw_cnt_q <= '0;
		else if (otw_cnt_q != 32'(OTW_FILT_CYCLES))
			otw_cnt_q <= otw_cnt_q + 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			otw_q <= 1'b0;
		else if (live && otw_over && otw_cnt_q == 32'(OTW_FILT_CYCLES))
			otw_q <= 1'b1;
		else if (otw_hys_s || in_sleep)
			otw_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Thermal shutdown
	logic [31:0] tsd_cnt_q;
	logic [31:0] tsd_rt_q;
	logic tsd_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			tsd_cnt_q <= '0;
		else if (!(live && tsd_s) || tsd_q)
			tsd_cnt_q <= '0;
		else if (tsd_cnt_q != 32'(TSD_FILT_CYCLES))
			tsd_cnt_q <= tsd_cnt_q + 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tsd_q <= 1'b0;
			tsd_rt_q <= '0;
		end else if (in_sleep) begin
			tsd_q <= 1'b0;
			tsd_rt_q <= '0;
		end else if (live && tsd_s && tsd_cnt_q == 32'(TSD_FILT_CYCLES)) begin
			tsd_q <= 1'b1;
			tsd_rt_q <= '0;
		end else if (tsd_q && tsd_retry_mode) begin
			// Clear time counts only while below hysteresis
			if (!tsd_hys_s)
				tsd_rt_q <= '0;
			else if (tsd_rt_q == 32'(TSD_CLEAR_CYCLES)) begin
				tsd_q <= 1'b0;
				tsd_rt_q <= '0;
			end else
				tsd_rt_q <= tsd_rt_q + 1'b1;
		end else if (tsd_q && clear_faults_command)
			tsd_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Fault output and records
	logic active_fault;
	assign active_fault = ocp_q || tsd_q || (otw_q && warning_report_enable);

	logic show_cmp;
	assign show_cmp = live && off_diagnostic_config_pin_on && in_standby &&
		(!SPI_VARIANT || !input_reg_unlocked);

	logic fault_q;
	logic rec_ocp_q;
	logic rec_ocp_hs_q;
	logic rec_tsd_q;

	// Latched sources fall with the clear itself, so gate them here;
	// a reported warning is a fresh set and wins over the clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fault_q <= 1'b0;
			rec_ocp_q <= 1'b0;
			rec_ocp_hs_q <= 1'b0;
			rec_tsd_q <= 1'b0;
		end else if (in_sleep) begin
			fault_q <= 1'b0;
			rec_ocp_q <= 1'b0;
			rec_ocp_hs_q <= 1'b0;
			rec_tsd_q <= 1'b0;
		end else begin
			fault_q <= (otw_q && warning_report_enable) ||
				((ocp_q || tsd_q || fault_q) &&
				!clear_faults_command);
			rec_ocp_q <= (ocp_q || rec_ocp_q) &&
				!clear_faults_command;
			rec_ocp_hs_q <= (ocp_hs_q || rec_ocp_hs_q) &&
				!clear_faults_command;
			rec_tsd_q <= (tsd_q || rec_tsd_q) &&
				!clear_faults_command;
		end
	end

	logic out_low;
	always_comb begin
		if (in_sleep)
			out_low = 1'b0;
		else if (show_cmp)
			out_low = !olp_s2_q;
		else if (SPI_VARIANT)
			out_low = fault_q;
		else
			out_low = active_fault;
	end

	logic out_low_q;
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			out_low_q <= 1'b0;
		else
			out_low_q <= out_low;
	end

	// Open drain: enable only while pulling low
	assign fault_flag_out_oe = out_low_q;
	assign fault_flag_out_n = 1'b0;

	assign output_hiz = ocp_q || tsd_q || in_sleep;
	assign current_sense_hiz = tsd_q || in_sleep;
	assign current_sense_pull_limit = ocp_hs_q && !tsd_q && !in_sleep;

	////////////////////////////////////////////////////////////////////////
	// Status reporting
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			report <= '0;
			status_frame <= 16'h0000;
		end else begin
			report.fault <= fault_q;
			report.overcurrent_protection <= rec_ocp_q;
			report.ocp_hs <= rec_ocp_hs_q;
			report.thermal_shutdown <= rec_tsd_q;
			report.temperature_warning_bit <= otw_q;
			report.off_state_comparator_result <= olp_s2_q;
			// First report in active, second in standby
			if (in_active)
				status_frame <= {8'h00, 3'h0, fault_q, rec_tsd_q, otw_q,
					rec_ocp_hs_q, rec_ocp_q};
			else
				status_frame <= {8'h00, 3'h0, fault_q, rec_tsd_q, otw_q,
					olp_s2_q, off_diagnostic_config_pin_on};
		end
	end

endmodule // hbd_fault_diagnostic_config_pin

// [hdl/hbd_pkg.sv]
// Package for the half-bridge fault and diagnostic control block.
// Assumes a single 50 MHz core clock domain.
package hbd_pkg;
	localparam int CLK_MHZ = 50;
	// Filter and clear times in microseconds; counts derived below.
	localparam int OCP_FILT_US_0 = 6;
	localparam int OCP_FILT_US_1 = 12;
	localparam int OTW_FILT_US = 100;
	localparam int TSD_FILT_US = 100;
	localparam int RETRY_US = 4000;
	localparam int CLEAR_US = 200;
	localparam int TSD_CLEAR_US = 200;
	localparam int OCP_FILT0_CYC = OCP_FILT_US_0 * CLK_MHZ;
	localparam int OCP_FILT1_CYC = OCP_FILT_US_1 * CLK_MHZ;
	localparam int OTW_FILT_CYC = OTW_FILT_US * CLK_MHZ;
	localparam int TSD_FILT_CYC = TSD_FILT_US * CLK_MHZ;
	localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
	localparam int CLEAR_CYC = CLEAR_US * CLK_MHZ;
	localparam int TSD_CLEAR_CYC = TSD_CLEAR_US * CLK_MHZ;
	localparam int CNT_W = 18;

	// Diagnostic select encodings
	localparam logic [1:0] DSEL_NONE = 2'h0;
	localparam logic [1:0] DSEL_OFF = 2'h1;
	localparam logic [1:0] DSEL_ON = 2'h2;
	localparam logic [1:0] DSEL_BOTH = 2'h3;
	localparam logic [1:0] DSEL_RST = 2'h0;

	typedef enum {ST_SLEEP, ST_STANDBY, ST_ACTIVE} hbd_state_e;

	typedef struct packed {
		logic fault;
		logic overcurrent_protection;
		logic ocp_hs;
		logic thermal_shutdown;
		logic temperature_warning_bit;
		logic off_state_comparator_result;
	} hbd_report_s;

	// Off-state setup applied to the output node
	typedef struct packed {
		logic pull_up;
		logic pull_down;
		logic ref_high;
	} hbd_olp_setup_s;
endpackage
